// >>> hw/pic_pkg.sv
// Shared constants and types of the priority interrupt controller.
package pic_pkg;

   // ****************************************************************
   // Sizes, bit positions and fixed byte values
   // ****************************************************************
   localparam int         PIC_NUM_LEVELS  = 8;
   localparam int         PIC_BIT_IW_FLAG = 4;
   localparam int         PIC_BIT_MODE    = 3;
   localparam int         PIC_BIT_END     = 5;
   localparam int         PIC_BIT_SPEC    = 6;
   localparam int         PIC_BIT_RD_ENA  = 1;
   localparam int         PIC_BIT_RD_SVC  = 0;
   localparam logic [7:0] PIC_CALL_OPCODE = 8'hcd;

   // ****************************************************************
   // Acknowledge pulse indices and values after reset
   // ****************************************************************
   localparam logic [1:0] PIC_ACK_FIRST = 2'h0;
   localparam logic [1:0] PIC_CALL_LAST = 2'h2;
   localparam logic [1:0] PIC_VEC_LAST  = 2'h1;
   localparam logic [7:0] PIC_BYTE_RST  = 8'h00;
   localparam logic [2:0] PIC_LVL_RST   = 3'h0;

   // Initialization sequence states.
   typedef enum logic [2:0]
   {
      PIC_ST_IDLE   = 3'b000,
      PIC_ST_SECOND = 3'b001,
      PIC_ST_THIRD  = 3'b010,
      PIC_ST_FOURTH = 3'b011,
      PIC_ST_READY  = 3'b100
   } pic_init_e;

   // Fields of the first initialization word, bit 4 left out.
   typedef struct packed
   {
      logic [2:0] addr_lo;
      logic       trigger_sel;
      logic       addr_gap_sel;
      logic       single;
      logic       need_fourth;
   } pic_first_s;

   // Fields of the fourth initialization word.
   typedef struct packed
   {
      logic ext_nest;
      logic buffered;
      logic buf_master;
      logic self_end;
      logic vector_mode;
   } pic_fourth_s;

   localparam pic_first_s  PIC_FIRST_RST  = '0;
   localparam pic_fourth_s PIC_FOURTH_RST = '0;

endpackage

// >>> hw/pic_prio_res.sv
// Fixed priority resolver: level 0 highest, level 7 lowest.
`timescale 1ns/1ps

module pic_prio_res
   import pic_pkg::*;
(
   input  wire logic [7:0] i_req,
   input  wire logic [7:0] i_mask,
   input  wire logic [7:0] i_svc,
   output logic            o_valid,
   output logic      [2:0] o_level
);

   // ****************************************************************
   // Pick the best unmasked request, then block it behind service
   // ****************************************************************
   // Scanning downward lets the lowest index overwrite the others.
   always_comb
   begin
      o_valid = 1'b0;
      o_level = PIC_LVL_RST;
      for (int i = PIC_NUM_LEVELS - 1; i >= 0; i--)
      begin
         if (i_req[i] && !i_mask[i])   // R24
         begin
            o_valid = 1'b1;
            o_level = 3'(i);
         end
      end
      for (int i = 0; i < PIC_NUM_LEVELS; i++)
      begin
         if (i_svc[i] && (3'(i) <= o_level))
            o_valid = 1'b0;            // R18
      end
   end

endmodule

// >>> hw/pic_req_sync.sv
// Request input synchronizers and edge or level request capture.
`timescale 1ns/1ps

module pic_req_sync
   import pic_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [7:0] i_req_async,
   input  wire logic       i_level_mode,
   input  wire logic [7:0] i_clr,
   input  wire logic       i_init,
   output logic      [7:0] o_req
);

   // ****************************************************************
   // One synchronizer and capture stage per level
   // ****************************************************************
   genvar g;
   for (g = 0; g < PIC_NUM_LEVELS; g++)
   begin : g_lvl
      logic meta;
      logic sync;
      logic prev;
      logic edge_seen;

      // Two stages before anything looks at the line; only sync is used.
      always_ff @(posedge i_clk or posedge i_rst)
      begin
         if (i_rst)
         begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
         end
         else
         begin
            meta <= i_req_async[g];   // R27
            sync <= meta;             // R27
            prev <= sync;
         end
      end

      // A rising edge wins over a clear in the same cycle, so it is never lost.
      always_ff @(posedge i_clk or posedge i_rst)
      begin
         if (i_rst)
            edge_seen <= 1'b0;
         else if (sync && !prev)
            edge_seen <= 1'b1;        // R26
         else if (i_clr[g] || i_init)
            edge_seen <= 1'b0;
      end

      // Level mode follows the line; edge mode holds the captured edge.
      assign o_req[g] = i_level_mode ? sync : edge_seen;   // R01 R26
   end

endmodule

// >>> hw/pic_top.sv
// Eight level priority interrupt controller with host port and acknowledge sequencer.
`timescale 1ns/1ps

// Functional notes
// [R01] Eight request inputs, each edge or level triggered by the first word.
// [R02] An accepted request drives the interrupt output high.
// [R03] A host write holds the interrupt output low while the strobe is low.
// [R04] The host gives three acknowledge pulses in call mode, two in vector mode.
// [R05] Acknowledge pulses carry a three byte call or one vector byte.
// [R06] Unbuffered: shared pin input, low means slave; ignored when single.
// [R07] Buffered: shared pin is a direction output, low while data bus drives.
// [R08] Cascade pins output in master mode, input in slave mode, values 0 to 7.
// [R09] In single mode cascade pins are outputs with meaningless values.
// [R10] Call mode sends the call opcode first, then two address bytes.
// [R11] Call mode sends low address byte second and high byte third.
// [R12] Software gives upper 11 address bits; the device adds level bits.
// [R13] Gap bit set: low byte is programmed 7..5, level 4..2, zero 1..0.
// [R14] Gap bit clear: programmed 7..6, level 5..3, zero 2..0.
// [R15] Vector byte is programmed upper five bits over the level number.
// [R16] Vector mode: first pulse internal only; second sends vector, sets service.
// [R17] Call mode sets the service bit on the pulse with the high byte.
// [R18] Interrupt only for the highest unmasked request above any in service.
// [R19] A peripheral holds its request high until the first acknowledge pulse.
// [R20] An end of interrupt command clears that level's service bit.
// [R21] Fourth word vector bit: zero call mode, one vector mode.
// [R22] Software writes the initialization words in order, at least once.
// [R23] After initialization the command words are taken any time, any order.
// [R24] A masked request is never accepted.
// [R25] A slave answers only when the cascade address equals its number.
// [R26] Trigger bit one selects level, zero selects rising edge.
// [R27] Each request passes a two stage synchronizer before detection.
// [R28] Data bus driven only in a selected read or the acknowledge answer.
// [R29] A master leaves the data bus to the slave owning the level.
module pic_top
   import pic_pkg::*;
(
   input  wire logic       I_CLK_SYS,
   input  wire logic       I_RST,
   input  wire logic       I_CS_N,
   input  wire logic       I_RD_N,
   input  wire logic       I_WR_N,
   input  wire logic       I_A0,
   input  wire logic [7:0] I_DATA,
   output logic      [7:0] O_DATA,
   output logic            O_DATA_OE_N,
   input  wire logic [7:0] I_PERIPH_REQ_IN,
   output logic            O_INT_REQ,
   input  wire logic       I_ACK_N,
   input  wire logic       I_SLAVE_SEL_N,
   output logic            O_XCVR_DIR_N,
   output logic            O_SEL_PIN_OE_N,
   input  wire logic [2:0] I_CASCADE_ADDR,
   output logic      [2:0] O_CASCADE_ADDR,
   output logic            O_CASCADE_OE_N
);

   // ****************************************************************
   // State and decode
   // ****************************************************************
   pic_init_e   init_state;
   pic_first_s  init_word_first;
   logic [7:0]  init_word_second;
   logic [7:0]  init_word_third;
   pic_fourth_s init_word_fourth;
   logic [7:0]  mask_bits;
   logic [7:0]  in_service_bits;
   logic [7:0]  request_bits;
   logic        rd_svc_sel;
   logic        wr_seen;
   logic        ack_prev;
   logic [1:0]  ack_cnt;
   logic [2:0]  ack_level;
   logic        sel_valid;
   logic [2:0]  sel_level;
   logic        wr_active;
   logic        wr_take;
   logic        rd_active;
   logic        is_first;
   logic        is_later;
   logic        is_prio_end;
   logic        is_mode_cmd;
   logic        ready;
   logic        single;
   logic        master;
   logic        master_cas;
   logic        slave_cas;
   logic        ack_fall;
   logic        ack_rise;
   logic [1:0]  ack_last;
   logic [2:0]  cur_level;
   logic        responder;
   logic        ack_drive;
   logic [7:0]  call_low;
   logic [7:0]  ack_byte;
   logic [7:0]  rd_byte;
   logic [7:0]  req_clr;
   logic [7:0]  svc_set;
   logic [7:0]  svc_clr;
   logic        next_oe;

   // Host strobes; both strobes low together is the disabled case.
   assign wr_active = !I_CS_N && !I_WR_N && I_RD_N;
   assign rd_active = !I_CS_N && !I_RD_N && I_WR_N;
   assign wr_take   = wr_active && !wr_seen;
   assign ready     = (init_state == PIC_ST_READY);
   assign is_first  = wr_take && !I_A0 && I_DATA[PIC_BIT_IW_FLAG];
   assign is_later  = wr_take && I_A0;
   assign is_prio_end = wr_take && !I_A0 && !I_DATA[PIC_BIT_IW_FLAG] && ready   // R23
                        && !I_DATA[PIC_BIT_MODE];
   assign is_mode_cmd = wr_take && !I_A0 && !I_DATA[PIC_BIT_IW_FLAG] && ready   // R23
                        && I_DATA[PIC_BIT_MODE];

   // Cascade role; the shared pin only counts when cascaded and unbuffered.
   assign single     = init_word_first.single;
   assign master     = init_word_fourth.buffered ? init_word_fourth.buf_master
                                                 : I_SLAVE_SEL_N;              // R06
   assign master_cas = !single && master;
   assign slave_cas  = !single && !master;

   // ****************************************************************
   // Request capture and priority
   // ****************************************************************
   pic_req_sync u_req_sync
   (
      .i_clk        (I_CLK_SYS),
      .i_rst        (I_RST),
      .i_req_async  (I_PERIPH_REQ_IN),
      .i_level_mode (init_word_first.trigger_sel),
      .i_clr        (req_clr),
      .i_init       (is_first),
      .o_req        (request_bits)
   );

   pic_prio_res u_prio_res
   (
      .i_req   (request_bits),
      .i_mask  (mask_bits),
      .i_svc   (in_service_bits),
      .o_valid (sel_valid),
      .o_level (sel_level)
   );

   // ****************************************************************
   // Initialization sequence and command words
   // ****************************************************************
   // The first word may restart the sequence at any time.
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
         init_state <= PIC_ST_IDLE;
      else if (is_first)
         init_state <= PIC_ST_SECOND;                                     // R22
      else if (is_later)
      begin
         case (init_state)
            PIC_ST_SECOND: init_state <= !single ? PIC_ST_THIRD :
                                         init_word_first.need_fourth ? PIC_ST_FOURTH :
                                         PIC_ST_READY;
            PIC_ST_THIRD:  init_state <= init_word_first.need_fourth ? PIC_ST_FOURTH :
                                         PIC_ST_READY;
            PIC_ST_FOURTH: init_state <= PIC_ST_READY;
            default:       init_state <= init_state;
         endcase
      end
   end

   // Initialization words land only in their own slot of the sequence.
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         init_word_first  <= PIC_FIRST_RST;
         init_word_second <= PIC_BYTE_RST;
         init_word_third  <= PIC_BYTE_RST;
         init_word_fourth <= PIC_FOURTH_RST;
      end
      else if (is_first)
      begin
         init_word_first  <= {I_DATA[7:5], I_DATA[3:0]};                   // R26 R12
         init_word_fourth <= PIC_FOURTH_RST;
      end
      else if (is_later && init_state == PIC_ST_SECOND)
         init_word_second <= I_DATA;                                      // R12 R15
      else if (is_later && init_state == PIC_ST_THIRD)
         init_word_third <= I_DATA;
      else if (is_later && init_state == PIC_ST_FOURTH)
         init_word_fourth <= I_DATA[4:0];                                 // R21
   end

   // Mask, read select and write edge tracking.
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         mask_bits  <= PIC_BYTE_RST;
         rd_svc_sel <= 1'b0;
         wr_seen    <= 1'b0;
      end
      else
      begin
         wr_seen <= wr_active;
         if (is_first)
         begin
            mask_bits  <= PIC_BYTE_RST;
            rd_svc_sel <= 1'b0;
         end
         else
         begin
            if (is_later && ready)
               mask_bits <= I_DATA;                                       // R23 R24
            if (is_mode_cmd && I_DATA[PIC_BIT_RD_ENA])
               rd_svc_sel <= I_DATA[PIC_BIT_RD_SVC];
         end
      end
   end

   // ****************************************************************
   // Acknowledge sequencer
   // ****************************************************************
   assign ack_fall  = !I_ACK_N && ack_prev;
   assign ack_rise  = I_ACK_N && !ack_prev;
   assign ack_last  = init_word_fourth.vector_mode ? PIC_VEC_LAST : PIC_CALL_LAST;   // R21 R04
   // Once the first pulse has fallen the latched level rules, since the winner may move.
   assign cur_level = (ack_cnt == PIC_ACK_FIRST && ack_prev) ? sel_level : ack_level;
   assign req_clr   = (ack_fall && ack_cnt == PIC_ACK_FIRST) ? (8'h01 << sel_level)
                                                              : 8'h00;
   assign svc_set   = (ack_fall && ack_cnt == ack_last) ? (8'h01 << ack_level)   // R16 R17
                                                         : 8'h00;

   // The pulse index advances as each pulse ends, so a byte holds for the pulse.
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         ack_prev  <= 1'b1;
         ack_cnt   <= PIC_ACK_FIRST;
         ack_level <= PIC_LVL_RST;
      end
      else
      begin
         ack_prev <= I_ACK_N;
         if (ack_fall && ack_cnt == PIC_ACK_FIRST)
            ack_level <= sel_level;                                       // R19
         if (is_first)
            ack_cnt <= PIC_ACK_FIRST;
         else if (ack_rise)
            ack_cnt <= (ack_cnt == ack_last) ? PIC_ACK_FIRST : 2'(ack_cnt + 2'h1);
      end
   end

   // Specific end clears the named level, otherwise the highest one in service.
   always_comb
   begin
      svc_clr = 8'h00;
      if (is_prio_end && I_DATA[PIC_BIT_END])
      begin
         if (I_DATA[PIC_BIT_SPEC])
            svc_clr = 8'h01 << I_DATA[2:0];                               // R20
         else
            svc_clr = in_service_bits & ~(in_service_bits - 8'h01);       // R20
      end
      if (ack_rise && ack_cnt == ack_last && init_word_fourth.self_end)
         svc_clr = svc_clr | (8'h01 << ack_level);
   end

   // A set in the same cycle as a clear wins.
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
         in_service_bits <= PIC_BYTE_RST;
      else if (is_first)
         in_service_bits <= PIC_BYTE_RST;
      else
         in_service_bits <= (in_service_bits & ~svc_clr) | svc_set;       // R16 R17 R20
   end

   // ****************************************************************
   // Data bus, direction pin and cascade pins
   // ****************************************************************
   // Eight byte spacing drops programmed bit 5 in favour of the level.
   assign call_low = init_word_first.addr_gap_sel
                     ? {init_word_first.addr_lo, cur_level, 2'b00}        // R13
                     : {init_word_first.addr_lo[2:1], cur_level, 3'b000}; // R14

   always_comb
   begin
      ack_byte = PIC_CALL_OPCODE;                                         // R10
      if (init_word_fourth.vector_mode)
         ack_byte = {init_word_second[7:3], cur_level};                   // R15
      else if (ack_cnt == 2'h1)
         ack_byte = call_low;                                             // R11
      else if (ack_cnt == PIC_CALL_LAST)
         ack_byte = init_word_second;                                     // R11
   end

   // Only the controller that owns the level answers the pulse.
   assign responder = single
                      || (master_cas && !init_word_third[cur_level])      // R29
                      || (slave_cas && I_CASCADE_ADDR == init_word_third[2:0]);   // R25
   assign ack_drive = ready && !I_ACK_N && responder
                      && !(init_word_fourth.vector_mode && ack_cnt == PIC_ACK_FIRST);  // R05 R16
   assign rd_byte   = I_A0 ? mask_bits : (rd_svc_sel ? in_service_bits : request_bits);
   assign next_oe   = ack_drive || rd_active;                             // R28

   // All pins are registered; they trail the strobes by one clock.
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_DATA         <= PIC_BYTE_RST;
         O_DATA_OE_N    <= 1'b1;
         O_XCVR_DIR_N   <= 1'b1;
         O_SEL_PIN_OE_N <= 1'b1;
         O_CASCADE_ADDR <= PIC_LVL_RST;
         O_CASCADE_OE_N <= 1'b0;
         O_INT_REQ      <= 1'b0;
      end
      else
      begin
         O_DATA         <= ack_drive ? ack_byte : rd_byte;                // R05
         O_DATA_OE_N    <= !next_oe;                                      // R28
         O_XCVR_DIR_N   <= !next_oe;                                      // R07
         O_SEL_PIN_OE_N <= !init_word_fourth.buffered;                    // R06 R07
         O_CASCADE_ADDR <= cur_level;                                     // R08 R09
         O_CASCADE_OE_N <= slave_cas;                                     // R08 R09
         O_INT_REQ      <= ready && sel_valid && ack_cnt == PIC_ACK_FIRST // R02 R18
                           && !wr_active;                                 // R03
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);

   a_int_write_low: assert property (wr_active |=> !O_INT_REQ)   // R03
      else $error("interrupt output high during a host write");
   a_int_has_cause: assert property (O_INT_REQ |-> $past(sel_valid) && $past(ready))   // R02
      else $error("interrupt output high with no accepted request");
   a_all_masked: assert property ((&mask_bits) |=> !O_INT_REQ)   // R24
      else $error("interrupt raised while every level is masked");
   a_call_opcode: assert property (ack_fall && ack_cnt == PIC_ACK_FIRST && single
      && ready && !init_word_fourth.vector_mode |=> !O_DATA_OE_N
      && O_DATA == PIC_CALL_OPCODE)   // R10
      else $error("call opcode missing on first pulse");
   a_call_high: assert property (ack_fall && ack_cnt == PIC_CALL_LAST && single && ready
      && !init_word_fourth.vector_mode |=> O_DATA == init_word_second)   // R11
      else $error("high address byte wrong on third pulse");
   a_vector_byte: assert property (ack_fall && ack_cnt == PIC_VEC_LAST && single && ready
      && init_word_fourth.vector_mode |=> O_DATA == {init_word_second[7:3], ack_level})   // R15
      else $error("vector byte wrong on second pulse");
   a_vector_first: assert property (ack_fall && ack_cnt == PIC_ACK_FIRST
      && init_word_fourth.vector_mode && I_CS_N |=> O_DATA_OE_N)   // R16
      else $error("data driven on first vector pulse");
   a_svc_set: assert property (ack_fall && ack_cnt == ack_last && !is_first
      |=> in_service_bits[$past(ack_level)])   // R17
      else $error("service bit not set on final pulse");
   a_bus_idle: assert property ((I_CS_N || I_RD_N) && I_ACK_N |=> O_DATA_OE_N)   // R28
      else $error("data bus driven outside read or answer");
   a_dir_follow: assert property (!O_SEL_PIN_OE_N |-> O_XCVR_DIR_N == O_DATA_OE_N)   // R07
      else $error("direction pin does not follow data enable");
   a_slave_pins: assert property (slave_cas |=> O_CASCADE_OE_N)   // R08
      else $error("slave drives the cascade pins");
   a_master_quiet: assert property (ack_fall && ack_cnt != PIC_ACK_FIRST && master_cas
      && init_word_third[ack_level] && I_CS_N |=> O_DATA_OE_N)   // R29
      else $error("master answered for a slave level");

   c_call_done: cover property (ack_rise && ack_cnt == PIC_CALL_LAST
      && !init_word_fourth.vector_mode);
   c_vector_done: cover property (ack_rise && ack_cnt == PIC_VEC_LAST
      && init_word_fourth.vector_mode);
   c_end_cmd: cover property (is_prio_end && I_DATA[PIC_BIT_END] && (|in_service_bits));
   c_slave_match: cover property (slave_cas && ack_drive);

endmodule

// >>> verification/pic_host_model.sv
// Host processor model that answers an interrupt with acknowledge pulses.
`timescale 1ns/1ps

module pic_host_model
(
   input  wire logic       i_clk,
   input  wire logic       i_oe_n,
   input  wire logic [7:0] i_data,
   output logic            o_ack_n
);
   logic [8:0] got [3];

   initial o_ack_n = 1'b1;

   // Each pulse is two cycles low, so the byte is read once it has settled.
   task automatic ack(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge i_clk) o_ack_n = 1'b0;
         repeat (2) @(negedge i_clk);
         got[i] = {i_oe_n, i_data};
         o_ack_n = 1'b1;
         repeat (2) @(negedge i_clk);
      end
   endtask
endmodule

// >>> verification/pic_top_bench.sv
// Self-checking bench for the priority interrupt controller.
`timescale 1ns/1ps

module pic_top_bench;
   import pic_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       cs_n = 1'b1;
   logic       rd_n = 1'b1;
   logic       wr_n = 1'b1;
   logic       a0 = 1'b0;
   logic [7:0] din = 8'h00;
   logic [7:0] req = 8'h00;
   logic [7:0] dout;
   logic       oe_n;
   logic       int_req;
   logic       ack_n;
   logic       dir_n;
   logic       sel_oe_n;
   logic [2:0] cas_out;
   logic       cas_oe_n;
   logic [2:0] cas_in = 3'h0;
   int         miscompares = 0;
   int         check_count = 0;
   int         cycles = 0;

   pic_top u_pic_top (.I_CLK_SYS(clk), .I_RST(rst), .I_CS_N(cs_n),
      .I_RD_N(rd_n), .I_WR_N(wr_n), .I_A0(a0), .I_DATA(din),
      .O_DATA(dout), .O_DATA_OE_N(oe_n), .I_PERIPH_REQ_IN(req),
      .O_INT_REQ(int_req), .I_ACK_N(ack_n), .I_SLAVE_SEL_N(1'b1),
      .O_XCVR_DIR_N(dir_n), .O_SEL_PIN_OE_N(sel_oe_n), .I_CASCADE_ADDR(cas_in),
      .O_CASCADE_ADDR(cas_out), .O_CASCADE_OE_N(cas_oe_n));

   pic_host_model u_pic_host_model (.i_clk(clk), .i_oe_n(oe_n),
      .i_data(dout), .o_ack_n(ack_n));

   // ****************************************************************
   // Clock, timeout and shared tasks
   // ****************************************************************
   always #2.5 clk = ~clk;

   // A hang is cut short well after the 170 or so cycles the run needs.
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         miscompares = miscompares + 1;
         tally_and_finish();
      end
   end

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // The strobe stays low for the given cycles, then a one cycle gap.
   task automatic wr(input logic addr, input logic [7:0] d, input int n);
      @(negedge clk);
      cs_n = 1'b0;
      wr_n = 1'b0;
      a0 = addr;
      din = d;
      repeat (n) @(negedge clk);
      cs_n = 1'b1;
      wr_n = 1'b1;
      @(negedge clk);
   endtask

   // One cycle read; the byte and the direction pin are looked at while they stand.
   task automatic rd_chk(input logic addr, input logic [7:0] exp);
      @(negedge clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      a0 = addr;
      @(negedge clk);
      check({oe_n, dout}, {1'b0, exp});
      check(dir_n, 1'b0);
      cs_n = 1'b1;
      rd_n = 1'b1;
      @(negedge clk);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Call mode, four byte gap, level 3: opcode, low byte, high byte.
   task automatic call_seq();
      wr(1'b0, 8'hb7, 1);
      wr(1'b1, 8'h12, 1);
      wr(1'b1, 8'h00, 1);
      check({int_req, oe_n}, 2'b01);
      req[3] = 1'b1;
      repeat (6) @(negedge clk);
      check(int_req, 1'b1);
      check({sel_oe_n, cas_oe_n, cas_out}, 5'b10011);
      u_pic_host_model.ack(3);
      check(u_pic_host_model.got[0], {1'b0, PIC_CALL_OPCODE});
      check(u_pic_host_model.got[1], 9'h0ac);
      check(u_pic_host_model.got[2], 9'h012);
      req[3] = 1'b0;
   endtask

   // Vector mode with level 5 masked: level 6 is served, writes drop INT.
   task automatic vec_seq();
      wr(1'b0, 8'h13, 1);
      wr(1'b1, 8'ha8, 1);
      wr(1'b1, 8'h01, 1);
      wr(1'b1, 8'h20, 1);
      req[6:5] = 2'b11;
      repeat (6) @(negedge clk);
      check(int_req, 1'b1);
      @(negedge clk);
      cs_n = 1'b0;
      wr_n = 1'b0;
      a0 = 1'b0;
      din = 8'h0a;
      repeat (3) @(negedge clk);
      check(int_req, 1'b0);
      cs_n = 1'b1;
      wr_n = 1'b1;
      repeat (3) @(negedge clk);
      check(int_req, 1'b1);
      u_pic_host_model.ack(2);
      check(u_pic_host_model.got[0][8], 1'b1);
      check(u_pic_host_model.got[1], 9'h0ae);
   endtask

   // Register reads, then a specific end command for the level left in service.
   task automatic svc_seq();
      rd_chk(1'b1, 8'h20);
      rd_chk(1'b0, 8'h20);
      wr(1'b0, 8'h0b, 1);
      rd_chk(1'b0, 8'h40);
      wr(1'b0, 8'h66, 1);
      rd_chk(1'b0, 8'h00);
   endtask

   // Level triggered call mode, eight byte gap, level 2; an end command reopens it.
   task automatic lvl_seq();
      req = 8'h00;
      wr(1'b0, 8'h5b, 1);
      wr(1'b1, 8'h34, 1);
      wr(1'b1, 8'h00, 1);
      req[2] = 1'b1;
      repeat (6) @(negedge clk);
      check(int_req, 1'b1);
      u_pic_host_model.ack(3);
      check(u_pic_host_model.got[1], 9'h050);
      check(u_pic_host_model.got[2], 9'h034);
      check(int_req, 1'b0);
      wr(1'b0, 8'h20, 1);
      check(int_req, 1'b1);
      wr(1'b1, 8'hff, 1);
      @(negedge clk);
      check(int_req, 1'b0);
      req[2] = 1'b0;
   endtask

   // Buffered cascade slave number 4 in vector mode answers its own address.
   task automatic slave_seq();
      wr(1'b0, 8'h11, 1);
      wr(1'b1, 8'h50, 1);
      wr(1'b1, 8'h04, 1);
      wr(1'b1, 8'h09, 1);
      req[1] = 1'b1;
      cas_in = 3'h4;
      repeat (6) @(negedge clk);
      check({int_req, sel_oe_n, cas_oe_n}, 3'b101);
      u_pic_host_model.ack(2);
      check(u_pic_host_model.got[1], 9'h051);
      req[1] = 1'b0;
   endtask

   initial
   begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      call_seq();
      vec_seq();
      svc_seq();
      lvl_seq();
      slave_seq();
      tally_and_finish();
   end
endmodule
